// ==== dmb_map.svh ====
// constants for data memory bank address formation
`ifndef DMB_MAP_SVH
`define DMB_MAP_SVH
`define DMB_ADDR_W      12
`define DMB_FA_W        8
`define DMB_BANK_W      4
`define DMB_NUM_BANKS   16
`define DMB_SPLIT_BIT   7
`define DMB_LOW_BANK    4'h0
`define DMB_HIGH_BANK   4'hF
`define DMB_BSR_RESET   8'h00
`define DMB_BSR_ADDR    12'hFE0
`define DMB_ZERO_DATA   8'h00
`define DMB_UPPER_ZERO  4'h0
`endif

// ==== dmb_pkg.sv ====
// types for data memory bank address formation
package dmb_pkg;
`include "dmb_map.svh"

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_MOVE = 2'b10
  } dmb_state_e_t;

  typedef struct packed {
    dmb_state_e_t               state;
    logic [`DMB_BANK_W-1:0]     bankSel;
    logic [`DMB_ADDR_W-1:0]     moveDst;
    logic [`DMB_ADDR_W-1:0]     ramAddr;
    logic                       ramWe;
    logic                       ramRe;
    logic [7:0]                 ramWdata;
    logic                       rdPend;
    logic                       zeroRd;
    logic                       bsrRd;
    logic [7:0]                 rdData;
    logic                       rdValid;
    logic                       flagUpd;
  } dmb_state_t;
endpackage

// ==== dmb_bank_addr.sv ====
// data memory address former with bank select and access window
`timescale 1ns/1ns
`include "dmb_map.svh"
module dmb_bank_addr #(
  parameter logic [15:0] IMPL_BANKS  = 16'h8001,
  parameter logic        REDUCED_PIN = 1'b0,
  parameter logic [11:0] ABSENT_LO   = 12'hF80,
  parameter logic [11:0] ABSENT_HI   = 12'hF8F
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // decoder operand request
  input  wire logic        opRead,
  input  wire logic        opWrite,
  input  wire logic        opAccess,
  input  wire logic [7:0]  opFileAddr,
  input  wire logic [7:0]  opWdata,
  input  wire logic        opStatusEn,
  // load bank literal instruction
  input  wire logic        loadBank,
  input  wire logic [7:0]  bankLiteral,
  // full address move instruction
  input  wire logic        moveReq,
  input  wire logic [11:0] moveSrc,
  input  wire logic [11:0] moveDst,
  // decoder answers
  output logic             reqReady,
  output logic [7:0]       rdData,
  output logic             rdValid,
  output logic             flagUpdate,
  output logic [7:0]       bankSelectValue,
  // data ram side
  output logic [11:0]      ramAddr,
  output logic             ramRe,
  output logic             ramWe,
  output logic [7:0]       ramWdata,
  input  wire logic [7:0]  ramRdata
);
  import dmb_pkg::*;

  dmb_state_t q;
  dmb_state_t d;
  logic [11:0] effAddr;
  logic [11:0] rdAddr;
  logic [11:0] wrAddr;
  logic [7:0]  wrData;
  logic        rdGo;
  logic        wrGo;
  logic [7:0]  readVal;
  logic        take;

  // all checks run on the core clock, off during reset
  default clocking cbCore @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // address yields no storage: dead bank or absent register
  function automatic logic noStore(input logic [11:0] a);
    logic dead;
    dead = !IMPL_BANKS[a[11:8]];
    if (REDUCED_PIN && a >= ABSENT_LO && a <= ABSENT_HI) begin
      dead = 1'b1;
    end
    return dead;
  endfunction

  // effective address from access bit, bank nibble and offset
  always_comb begin
    if (opAccess) begin
      effAddr = {q.bankSel, opFileAddr};
    end else if (opFileAddr[`DMB_SPLIT_BIT]) begin
      effAddr = {`DMB_HIGH_BANK, opFileAddr};
    end else begin
      effAddr = {`DMB_LOW_BANK, opFileAddr};
    end
  end

  // returned byte: zero, bank select, or ram
  always_comb begin
    if (q.zeroRd) begin
      readVal = `DMB_ZERO_DATA;
    end else if (q.bsrRd) begin
      readVal = {`DMB_UPPER_ZERO, q.bankSel};
    end else begin
      readVal = ramRdata;
    end
  end

  assign take = (q.state == ST_IDLE) &&
                (loadBank || moveReq || opRead || opWrite);

  // next state
  always_comb begin
    d = q;
    d.ramWe   = 1'b0;
    d.ramRe   = 1'b0;
    d.rdValid = 1'b0;
    d.flagUpd = 1'b0;
    d.rdPend  = 1'b0;
    rdGo   = 1'b0;
    wrGo   = 1'b0;
    rdAddr = effAddr;
    wrAddr = effAddr;
    wrData = opWdata;
    if (q.rdPend) begin
      d.rdValid = 1'b1;
      d.rdData  = readVal;
    end
    case (q.state)
      ST_IDLE: begin
        if (loadBank) begin
          d.bankSel = bankLiteral[`DMB_BANK_W-1:0];
        end else if (moveReq) begin
          rdGo    = 1'b1;
          rdAddr  = moveSrc;
          d.moveDst = moveDst;
          d.state = ST_MOVE;
        end else if (opRead || opWrite) begin
          rdGo = opRead;
          wrGo = opWrite && !opRead;
          d.rdPend  = opRead;
          d.flagUpd = opStatusEn;
        end
      end
      ST_MOVE: begin
        wrGo    = 1'b1;
        wrAddr  = q.moveDst;
        wrData  = readVal;
        d.state = ST_IDLE;
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase
    // common read launch
    if (rdGo) begin
      d.ramAddr = rdAddr;
      d.ramRe   = !noStore(rdAddr);
      d.zeroRd  = noStore(rdAddr);
      d.bsrRd   = (rdAddr == `DMB_BSR_ADDR);
    end
    // common write launch; bank select lives at its own address
    if (wrGo) begin
      d.ramAddr  = wrAddr;
      d.ramWdata = wrData;
      if (wrAddr == `DMB_BSR_ADDR) begin
        d.bankSel = wrData[`DMB_BANK_W-1:0];
      end else begin
        d.ramWe = !noStore(wrAddr);
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q         <= '0;
      q.state   <= ST_IDLE;
      q.bankSel <= 4'(`DMB_BSR_RESET); // only the nibble is stored
    end else begin
      q <= d;
    end
  end

  // outputs
  assign reqReady        = (q.state == ST_IDLE);
  assign rdData          = q.rdData;
  assign rdValid         = q.rdValid;
  assign flagUpdate      = q.flagUpd;
  assign bankSelectValue = {`DMB_UPPER_ZERO, q.bankSel};
  assign ramAddr         = q.ramAddr;
  assign ramRe           = q.ramRe;
  assign ramWe           = q.ramWe;
  assign ramWdata        = q.ramWdata;

  // checks, on the default clock and reset
  a_bank_upper_zero: assert property
    (bankSelectValue[7:4] == 4'h0)
    else $error("bank select upper bits not zero");

  a_bsr_write: assert property
    (take && opWrite && !opRead && !loadBank && !moveReq &&
    effAddr == `DMB_BSR_ADDR |=>
    bankSelectValue == {4'h0, $past(opWdata[3:0])})
    else $error("bank select write lost");

  a_banked_addr: assert property
    (take && !loadBank && !moveReq && opAccess |=>
    ramAddr == {$past(q.bankSel), $past(opFileAddr)})
    else $error("banked address wrong");

  a_window_low: assert property
    (take && !loadBank && !moveReq && !opAccess && !opFileAddr[7] |=>
    ramAddr == {4'h0, $past(opFileAddr)})
    else $error("low window address wrong");

  a_window_high: assert property
    (take && !loadBank && !moveReq && !opAccess && opFileAddr[7] |=>
    ramAddr == {4'hF, $past(opFileAddr)})
    else $error("high window address wrong");

  a_write_data: assert property
    (take && opWrite && !opRead && !loadBank && !moveReq |=>
    ramWdata == $past(opWdata))
    else $error("write data wrong");

  a_dead_no_write: assert property
    (ramWe |-> IMPL_BANKS[ramAddr[11:8]])
    else $error("write reached unimplemented bank");

  a_dead_read_zero: assert property
    (ramRe == 1'b0 && $rose(q.rdPend) && q.zeroRd |=>
    rdValid && rdData == 8'h00)
    else $error("unimplemented bank read not zero");

  a_read_valid: assert property
    (take && opRead && !loadBank && !moveReq |=> ##1 rdValid)
    else $error("read result missing");

  a_flags_kept: assert property
    (take && !loadBank && !moveReq && opStatusEn |=> flagUpdate ##1
    (!flagUpdate || $past(take && !loadBank && !moveReq && opStatusEn)))
    else $error("flag update lost");

  a_load_bank: assert property
    (take && loadBank |=> bankSelectValue == {4'h0, $past(bankLiteral[3:0])})
    else $error("bank literal not loaded");

  a_move_addr: assert property
    (take && !loadBank && moveReq |=>
    ramAddr == $past(moveSrc) && !reqReady ##1
    ramAddr == $past(moveDst, 2) && reqReady)
    else $error("full move addresses wrong");
endmodule

// ==== dmb_ram_model.sv ====
// data ram model behind the address former
`timescale 1ns/1ns
module dmb_ram_model (
  // clock
  input  wire logic        sys_clk,
  // ram port
  input  wire logic [11:0] ramAddr,
  input  wire logic        ramRe,
  input  wire logic        ramWe,
  input  wire logic [7:0]  ramWdata,
  output logic [7:0]       ramRdata
);
  logic [7:0] mem [4096];
  logic [7:0] junk = 8'h5A;
  initial foreach (mem[i]) mem[i] = 8'h00;
  // store on write strobe, scramble the idle read bus
  always @(posedge sys_clk) begin
    if (ramWe) mem[ramAddr] <= ramWdata;
    junk <= ~junk + 8'h01;
  end
  // data only valid while read strobe is up
  assign ramRdata = ramRe ? mem[ramAddr] : junk;
endmodule

// ==== test_dmb_bank_addr.sv ====
// self-checking bench for the data memory address former
`timescale 1ns/1ns
module test_dmb_bank_addr;
  logic        sys_clk = 0, reset_n = 0, opRead = 0, opWrite = 0;
  logic        opAccess = 0, opStatusEn = 0, loadBank = 0, moveReq = 0;
  logic [7:0]  opFileAddr = 0, opWdata = 0, bankLiteral = 0;
  logic [11:0] moveSrc = 0, moveDst = 0, ramAddr;
  logic [7:0]  rdData, bankSelectValue, ramWdata, ramRdata;
  logic        reqReady, rdValid, flagUpdate, ramRe, ramWe;
  int          num_errors = 0, n_tests = 0, nib = 0, mem[int];
  logic [31:0] seed = 10;
  dmb_bank_addr #(.IMPL_BANKS(16'h8003), .REDUCED_PIN(1'b1)) dut (.sys_clk,
    .reset_n, .opRead, .opWrite, .opAccess, .opFileAddr, .opWdata,
    .opStatusEn, .loadBank, .bankLiteral, .moveReq, .moveSrc, .moveDst,
    .reqReady, .rdData, .rdValid, .flagUpdate, .bankSelectValue, .ramAddr,
    .ramRe, .ramWe, .ramWdata, .ramRdata);
  dmb_ram_model ram (.sys_clk, .ramAddr, .ramRe, .ramWe, .ramWdata,
    .ramRdata);
  always #5 sys_clk = ~sys_clk;
  // xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // banks 0,1,15 exist; F80-F8F absent on the reduced part
  function automatic bit live(int a);
    return (a[11:8] inside {0, 1, 15}) && !(a inside {['hF80:'hF8F]});
  endfunction
  function automatic int rd(int a);
    if (a == 'hFE0) return nib;
    return (live(a) && mem.exists(a)) ? mem[a] : 0;
  endfunction
  function automatic int pick();
    int b = xs() % 4;
    return {b == 3 ? 4'hF : 4'(b), 8'(xs())};
  endfunction
  task automatic chk(logic [11:0] seen, logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic setBank(logic [7:0] lit);
    @(posedge sys_clk);
    loadBank <= 1;
    bankLiteral <= lit;
    @(posedge sys_clk);
    loadBank <= 0;
    #1;
    nib = lit[3:0];
    chk(bankSelectValue, nib);
  endtask
  // one operand read or write, checked over two cycles
  task automatic access(bit wr, bit acc, logic [7:0] fa, bit st);
    int a = acc ? {nib[3:0], fa} : {fa[7] ? 4'hF : 4'h0, fa};
    logic [7:0] d = 8'(xs());
    @(posedge sys_clk);
    opRead <= !wr;
    opWrite <= wr;
    opAccess <= acc;
    opFileAddr <= fa;
    opWdata <= d;
    opStatusEn <= st;
    @(posedge sys_clk);
    opRead <= 0;
    opWrite <= 0;
    #1;
    chk(flagUpdate, st);
    if (a != 'hFE0) begin
      chk(ramAddr, a);
      chk(wr ? ramWe : ramRe, live(a));
      if (wr && live(a)) chk(ramWdata, d);
    end
    if (wr && a == 'hFE0) nib = d[3:0];
    else if (wr && live(a)) mem[a] = d;
    @(posedge sys_clk);
    #1;
    if (!wr) chk(rdData, rd(a));
    if (!wr) chk(rdValid, 1);
    chk(bankSelectValue, nib);
  endtask
  // full address move, with a read offered in the busy cycle
  task automatic move(int s, int t);
    int v = rd(s);
    @(posedge sys_clk);
    moveReq <= 1;
    moveSrc <= s;
    moveDst <= t;
    @(posedge sys_clk);
    moveReq <= 0;
    opRead <= 1;
    #1;
    chk(reqReady, 0);
    if (s != 'hFE0) chk(ramAddr, s);
    if (s != 'hFE0) chk(ramRe, live(s));
    @(posedge sys_clk);
    opRead <= 0;
    #1;
    // a move onto the bank select address loads the nibble, no ram write
    chk(ramWe, live(t) && t != 'hFE0);
    chk(ramRe, 0);
    if (live(t)) chk(ramWdata, v);
    if (t == 'hFE0) nib = v & 'hF;
    else if (live(t)) mem[t] = v;
    chk(bankSelectValue, nib);
  endtask
  task automatic results();
    $display("%0d checks, %0d mismatches", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    results();
  end
  initial begin
    logic [31:0] r;
    logic [7:0]  win [5] = '{8'h7F, 8'h80, 8'h00, 8'hFF, 8'h85};
    repeat (3) @(posedge sys_clk);
    reset_n <= 1;
    #1;
    chk(bankSelectValue, 0);
    chk(reqReady, 1);
    for (int i = 0; i < 16; i++) begin
      r = xs();
      setBank({r[7:4], 4'(i)});
      access(1, 1, r[15:8], 1);
      access(0, 1, r[15:8], 0);
    end
    $display("bank sweep done");
    // window edges: top of low region, bottom of high, ends, absent range
    foreach (win[i]) begin
      access(1, 0, win[i], 1);
      access(0, 0, win[i], 1);
    end
    access(1, 0, 8'hE0, 0);
    access(0, 0, 8'hE0, 0);
    $display("window test done");
    for (int i = 0; i < 400; i++) begin
      r = xs();
      case (r[1:0])
        2'd0: setBank(r[15:8]);
        2'd1: move(pick(), pick());
        default: access(r[4], r[5], r[15:8], r[6]);
      endcase
    end
    $display("random mix done");
    results();
  end
endmodule
